/* design/rtc_calendar_alarm.sv */
`timescale 1ns/1ps
`include "rtc_defs.svh"
// Behaviour
// - Calendar 2000-01-01 to 2099-12-31, leap aware
// - Hours count 00 to 23 only
// - One second steps, half second phase visible
// - All time and alarm values in BCD
// - Weekday, day, month, year carry consistently
// - Second derived from 32.768 kHz ticks
// - Calibration adjusts count hourly, up to about 2.8 s/month
// - Pin carries alarm pulse or seconds clock
// - Arm bit; self-clears when count zero, chime off
// - Repeat count decrements; chime wraps to 0xff
// - Interval field selects ten alarm periods
// - Yearly alarm on February 29 only leap years
// - Window index selects alarm byte pairs
// - High window access decrements index to zero
// - Repeat count means further alarms after this
// - Alarm configuration readable, writable, resets zero
module rtc_calendar_alarm import rtc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_tick_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic rtc_pin_o,
  output logic rtc_pin_oe_o
);
  // ****************************************
  // Declarations
  // ****************************************
  logic half_tick, sec_tick, half_phase; // Timebase outputs
  logic half_d, sec_d; // Pulses delayed until the calendar has moved
  logic [23:0] tm; // Hours, minutes, seconds
  logic [31:0] dt; // Year, month, day, weekday
  logic [31:0] ctrl, next_ctrl; // Run, pin enable, pin select, calibration
  logic [15:0] cfg, next_cfg; // Alarm configuration and repeat count
  bcd_t a_sec, a_min, a_hr, a_wd, a_day, a_mon; // Stored alarm value
  bcd_t next_a_sec, next_a_min, next_a_hr, next_a_wd, next_a_day, next_a_mon;
  logic [1:0] irq_st, next_irq_st; // Sticky event bits
  logic [1:0] irq_mask, next_irq_mask;
  logic next_irq;
  logic next_ack;
  logic [31:0] next_dat;
  logic [15:0] win; // Alarm window at the current index
  logic acc, wr; // Bus access completing this edge, and a write
  logic [31:0] wmerge; // Write data merged into the addressed register
  logic [31:0] rd_cur; // Current content of the addressed register
  logic time_load, date_load, cal_req;
  logic strobe, hit, fire; // Alarm compare strobe, match, event
  logic pulse, next_pulse; // Stretched alarm pulse
  logic next_pin, next_pin_oe;
  logic sm, mm, hm, wm, dm, mo; // Per field matches
  interval_t mode;

  // Byte lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // Timebase and calendar
  // ****************************************
  rtc_timebase u_timebase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_tick_i(osc_tick_i),
    .run_i(ctrl[`CTRL_RUN]),
    .restart_i(time_load),
    .cal_req_i(cal_req),
    .cal_i(ctrl[`CTRL_CAL]),
    .half_tick_o(half_tick),
    .sec_tick_o(sec_tick),
    .half_phase_o(half_phase)
  );

  rtc_calendar u_calendar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sec_tick_i(sec_tick),
    .time_load_i(time_load),
    .time_val_i(wmerge[23:0]),
    .date_load_i(date_load),
    .date_val_i(wmerge),
    .time_o(tm),
    .date_o(dt)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  // Alarm window pair at the current index; the unused code reads zero
  always_comb begin
    case (window_index_t'(cfg[`ACF_PTR]))
      WIN_SEC_MIN: win = {a_min, a_sec};
      WIN_HR_WD: win = {a_wd, a_hr};
      WIN_DAY_MON: win = {a_mon, a_day};
      default: win = 16'h0000;
    endcase
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    case (wb_adr_i)
      `REG_TIME: rd_cur = {7'h00, half_phase, tm};
      `REG_DATE: rd_cur = dt;
      `REG_CTRL: rd_cur = ctrl;
      `REG_ALCFG: rd_cur = {16'h0000, cfg};
      `REG_ALVAL: rd_cur = {16'h0000, win};
      `REG_IRQ_ST: rd_cur = {30'h0, irq_st};
      `REG_IRQ_MASK: rd_cur = {30'h0, irq_mask};
      default: rd_cur = 32'h00000000;
    endcase
  end

  // Ack one cycle after the request; every side effect happens on the
  // edge where the master sees ack, so a held request acts only once
  always_comb begin
    acc = wb_cyc_i & wb_stb_i & wb_ack_o;
    wr = acc & wb_we_i;
    wmerge = lane_merge(rd_cur, wb_dat_i, wb_sel_i);
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = wb_dat_o;
    if (next_ack && !wb_we_i) next_dat = rd_cur;
    time_load = wr && (wb_adr_i == `REG_TIME);
    date_load = wr && (wb_adr_i == `REG_DATE);
  end

  // Register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ****************************************
  // Control and calibration
  // ****************************************
  // Calibration is requested at the top of every hour
  always_comb begin
    next_ctrl = ctrl;
    if (wr && wb_adr_i == `REG_CTRL) next_ctrl = {16'h0000, wmerge[15:8], 5'h00, wmerge[2:0]};
    cal_req = sec_d && tm[`T_MIN] == `BCD_ZERO && tm[`T_SEC] == `BCD_ZERO;
  end

  // Register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
      half_d <= 1'b0;
      sec_d <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      half_d <= half_tick;
      sec_d <= sec_tick;
    end
  end

  // ****************************************
  // Alarm compare
  // ****************************************
  // Fields outside the interval are ignored; compare after the calendar
  // has stepped, so the match sees the new second
  always_comb begin
    mode = interval_t'(cfg[`ACF_MASK]);
    sm = tm[`T_SEC] == a_sec;
    mm = tm[`T_MIN] == a_min;
    hm = tm[`T_HR] == a_hr;
    wm = dt[`D_WD] == a_wd;
    dm = dt[`D_DAY] == a_day;
    mo = dt[`D_MON] == a_mon;
    strobe = (mode == IV_HALF) ? half_d : sec_d;
    case (mode)
      IV_HALF: hit = 1'b1;
      IV_SEC: hit = 1'b1;
      IV_10SEC: hit = tm[3:0] == a_sec[3:0];
      IV_MIN: hit = sm;
      IV_10MIN: hit = sm & (tm[11:8] == a_min[3:0]);
      IV_HOUR: hit = sm & mm;
      IV_DAY: hit = sm & mm & hm;
      IV_WEEK: hit = sm & mm & hm & wm;
      IV_MONTH: hit = sm & mm & hm & dm;
      // February 29 only exists in leap years, so it matches once in four
      IV_YEAR: hit = sm & mm & hm & dm & mo;
      // Reserved codes never match; software must not use them
      default: hit = 1'b0;
    endcase
    fire = cfg[`ACF_ARM] & strobe & hit;
  end

  // ****************************************
  // Alarm configuration and value window
  // ****************************************
  // An alarm event in the same cycle as a write wins over the write
  always_comb begin
    next_cfg = cfg;
    next_a_sec = a_sec;
    next_a_min = a_min;
    next_a_hr = a_hr;
    next_a_wd = a_wd;
    next_a_day = a_day;
    next_a_mon = a_mon;
    if (wr && wb_adr_i == `REG_ALCFG) next_cfg = wmerge[15:0];
    if (wr && wb_adr_i == `REG_ALVAL) begin
      case (window_index_t'(cfg[`ACF_PTR]))
        WIN_SEC_MIN: begin
          next_a_min = wmerge[15:8];
          next_a_sec = wmerge[7:0];
        end
        WIN_HR_WD: begin
          next_a_wd = wmerge[15:8];
          next_a_hr = wmerge[7:0];
        end
        WIN_DAY_MON: begin
          next_a_mon = wmerge[15:8];
          next_a_day = wmerge[7:0];
        end
        default: begin
          // Unimplemented pair: writes are dropped
        end
      endcase
    end
    // Reads and writes of the high byte step the index down to zero
    if (acc && wb_adr_i == `REG_ALVAL && wb_sel_i[1] && cfg[`ACF_PTR] != 2'b00) begin
      next_cfg[`ACF_PTR] = cfg[`ACF_PTR] - 2'b01;
    end
    if (fire) begin
      if (cfg[`ACF_RPT] != `BCD_ZERO) begin
        next_cfg[`ACF_RPT] = cfg[`ACF_RPT] - 8'h01;
      end else if (cfg[`ACF_CHIME]) begin
        next_cfg[`ACF_RPT] = `RPT_WRAP;
      end else begin
        next_cfg[`ACF_ARM] = 1'b0;
      end
    end
  end

  // Register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= `ACF_RESET;
      a_sec <= `BCD_ZERO;
      a_min <= `BCD_ZERO;
      a_hr <= `BCD_ZERO;
      a_wd <= `BCD_ZERO;
      a_day <= `BCD_ZERO;
      a_mon <= `BCD_ZERO;
    end else begin
      cfg <= next_cfg;
      a_sec <= next_a_sec;
      a_min <= next_a_min;
      a_hr <= next_a_hr;
      a_wd <= next_a_wd;
      a_day <= next_a_day;
      a_mon <= next_a_mon;
    end
  end

  // ****************************************
  // Interrupts and output pin
  // ****************************************
  // Write one to clear; a new event in the same cycle keeps its bit set
  always_comb begin
    next_irq_st = irq_st;
    next_irq_mask = irq_mask;
    if (wr && wb_adr_i == `REG_IRQ_ST) next_irq_st = irq_st & ~wmerge[1:0];
    if (wr && wb_adr_i == `REG_IRQ_MASK) next_irq_mask = wmerge[1:0];
    next_irq_st[`IRQ_ALARM] = next_irq_st[`IRQ_ALARM] | fire;
    next_irq_st[`IRQ_SEC] = next_irq_st[`IRQ_SEC] | sec_d;
    next_irq = |(next_irq_st & next_irq_mask);
  end

  // Pin: alarm pulse lasts to the next half second; the seconds clock is
  // high in the first half of each second
  always_comb begin
    next_pulse = pulse;
    if (half_tick) next_pulse = 1'b0;
    if (fire) next_pulse = 1'b1;
    next_pin_oe = ctrl[`CTRL_PIN_EN];
    next_pin = 1'b0;
    if (ctrl[`CTRL_PIN_EN]) begin
      next_pin = ctrl[`CTRL_PIN_SEL] ? ~half_phase : pulse;
    end
  end

  // Register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= 2'b00;
      irq_mask <= 2'b00;
      irq_o <= 1'b0;
      pulse <= 1'b0;
      rtc_pin_o <= 1'b0;
      rtc_pin_oe_o <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      irq_o <= next_irq;
      pulse <= next_pulse;
      rtc_pin_o <= next_pin;
      rtc_pin_oe_o <= next_pin_oe;
    end
  end
endmodule // rtc_calendar_alarm

/* design/rtc_defs.svh */
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// ****************************************
// Timebase
// ****************************************
// Oscillator ticks per second, and last tick index of each half second
`define OSC_HZ 32768
`define HALF_LAST 15'd16383
// ****************************************
// Register byte offsets
// ****************************************
`define REG_TIME 5'h00
`define REG_DATE 5'h04
`define REG_CTRL 5'h08
`define REG_ALCFG 5'h0c
`define REG_ALVAL 5'h10
`define REG_IRQ_ST 5'h14
`define REG_IRQ_MASK 5'h18
// ****************************************
// Field positions
// ****************************************
`define CTRL_RUN 0
`define CTRL_PIN_EN 1
`define CTRL_PIN_SEL 2
`define CTRL_CAL 15:8
`define ACF_ARM 15
`define ACF_CHIME 14
`define ACF_MASK 13:10
`define ACF_PTR 9:8
`define ACF_RPT 7:0
`define IRQ_ALARM 0
`define IRQ_SEC 1
`define T_HR 23:16
`define T_MIN 15:8
`define T_SEC 7:0
`define D_YR 31:24
`define D_MON 23:16
`define D_DAY 15:8
`define D_WD 7:0
// ****************************************
// Reset values and BCD limits
// ****************************************
`define CTRL_RESET 32'h00000001
`define ACF_RESET 16'h0000
`define TIME_RESET 24'h000000
`define DATE_RESET 32'h00010106
`define BCD_ZERO 8'h00
`define BCD_ONE 8'h01
`define BCD_SEC_MAX 8'h59
`define BCD_HR_MAX 8'h23
`define BCD_WD_MAX 8'h06
`define BCD_MON_MAX 8'h12
`define BCD_YR_MAX 8'h99
`define RPT_WRAP 8'hff
`endif

/* design/rtc_pkg.sv */
package rtc_pkg;
  // One BCD byte, two digits
  typedef logic [7:0] bcd_t;
  // Alarm interval codes
  typedef enum logic [3:0] {
    IV_HALF = 4'h0, IV_SEC = 4'h1, IV_10SEC = 4'h2, IV_MIN = 4'h3,
    IV_10MIN = 4'h4, IV_HOUR = 4'h5, IV_DAY = 4'h6, IV_WEEK = 4'h7,
    IV_MONTH = 4'h8, IV_YEAR = 4'h9
  } interval_t;
  // Alarm window index codes
  typedef enum logic [1:0] {
    WIN_SEC_MIN = 2'b00, WIN_HR_WD = 2'b01, WIN_DAY_MON = 2'b10, WIN_NONE = 2'b11
  } window_index_t;
endpackage

/* design/rtc_timebase.sv */
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_timebase import rtc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_tick_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic cal_req_i,
  input wire logic [7:0] cal_i,
  output logic half_tick_o,
  output logic sec_tick_o,
  output logic half_phase_o
);
  logic [14:0] cnt, next_cnt; // Ticks within the current half second
  logic pend, next_pend; // Calibration waiting for the next half period
  logic next_half, next_sec, next_phase;
  logic [15:0] last; // Terminal tick, shifted by calibration

  // Positive calibration shortens one half period, so the clock gains
  always_comb begin
    last = pend ? {1'b0, `HALF_LAST} - {{8{cal_i[7]}}, cal_i} : {1'b0, `HALF_LAST};
    next_cnt = cnt;
    next_pend = pend | cal_req_i;
    next_half = 1'b0;
    next_sec = 1'b0;
    next_phase = half_phase_o;
    if (restart_i) begin // A time write starts a fresh second
      next_cnt = 15'd0;
      next_phase = 1'b0;
    end else if (run_i && osc_tick_i) begin
      if ({1'b0, cnt} >= last) begin
        next_cnt = 15'd0;
        next_half = 1'b1;
        next_sec = half_phase_o;
        next_phase = ~half_phase_o;
        next_pend = cal_req_i;
      end else begin
        next_cnt = cnt + 15'd1;
      end
    end
  end

  // Register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 15'd0;
      pend <= 1'b0;
      half_tick_o <= 1'b0;
      sec_tick_o <= 1'b0;
      half_phase_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pend <= next_pend;
      half_tick_o <= next_half;
      sec_tick_o <= next_sec;
      half_phase_o <= next_phase;
    end
  end
endmodule // rtc_timebase

/* design/rtc_calendar.sv */
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_calendar import rtc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sec_tick_i,
  input wire logic time_load_i,
  input wire logic [23:0] time_val_i,
  input wire logic date_load_i,
  input wire logic [31:0] date_val_i,
  output logic [23:0] time_o,
  output logic [31:0] date_o
);
  logic [23:0] next_time;
  logic [31:0] next_date;
  bcd_t dim; // Last day of the current month
  logic leap;

  // BCD increment of a two digit value
  function automatic bcd_t bcd_inc(input bcd_t v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Every fourth year from 2000 is leap; 2000 itself is leap
  always_comb begin
    leap = date_o[28] ? (date_o[27:24] == 4'h2 || date_o[27:24] == 4'h6)
                     : (date_o[27:24] == 4'h0 || date_o[27:24] == 4'h4 ||
                        date_o[27:24] == 4'h8);
    case (date_o[`D_MON])
      8'h02: dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  end

  // Carry chain from seconds up to year, all in BCD
  always_comb begin
    next_time = time_o;
    next_date = date_o;
    if (time_load_i || date_load_i) begin
      if (time_load_i) next_time = time_val_i;
      if (date_load_i) next_date = date_val_i;
    end else if (sec_tick_i) begin
      next_time[`T_SEC] = bcd_inc(time_o[`T_SEC]);
      if (time_o[`T_SEC] == `BCD_SEC_MAX) begin
        next_time[`T_SEC] = `BCD_ZERO;
        next_time[`T_MIN] = bcd_inc(time_o[`T_MIN]);
        if (time_o[`T_MIN] == `BCD_SEC_MAX) begin
          next_time[`T_MIN] = `BCD_ZERO;
          next_time[`T_HR] = bcd_inc(time_o[`T_HR]);
          if (time_o[`T_HR] == `BCD_HR_MAX) begin
            next_time[`T_HR] = `BCD_ZERO;
            next_date[`D_WD] = (date_o[`D_WD] == `BCD_WD_MAX) ? `BCD_ZERO
                                                            : bcd_inc(date_o[`D_WD]);
            next_date[`D_DAY] = bcd_inc(date_o[`D_DAY]);
            if (date_o[`D_DAY] == dim) begin
              next_date[`D_DAY] = `BCD_ONE;
              next_date[`D_MON] = bcd_inc(date_o[`D_MON]);
              if (date_o[`D_MON] == `BCD_MON_MAX) begin
                next_date[`D_MON] = `BCD_ONE;
                next_date[`D_YR] = (date_o[`D_YR] == `BCD_YR_MAX) ? `BCD_ZERO
                                                                : bcd_inc(date_o[`D_YR]);
              end
            end
          end
        end
      end
    end
  end

  // Register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_o <= `TIME_RESET;
      date_o <= `DATE_RESET;
    end else begin
      time_o <= next_time;
      date_o <= next_date;
    end
  end
endmodule // rtc_calendar

/* verification/rtc_calendar_alarm_chk.sv */
`timescale 1ns/1ps
// ****
// Port-level checks
// ****
module rtc_calendar_alarm_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic rtc_pin_o,
  input wire logic rtc_pin_oe_o
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Every request is answered in the next cycle
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  // Ack is a single-cycle pulse
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // No ack without a request before it
  no_stray_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // Outputs come out of reset quiet
  reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !rtc_pin_oe_o)
    else $error("outputs active after reset");
  // Read data changes only when a read is answered
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed without a read");
  // Interrupt drops only after a software write (clear or mask)
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("interrupt dropped without a write");
  // Disabled pin stays low
  pin_gated_a: assert property (!rtc_pin_oe_o |-> !rtc_pin_o)
    else $error("pin driven while disabled");
  // Pin enable follows a control write, with one or two cycles of lag
  oe_change_a: assert property ($changed(rtc_pin_oe_o) |->
    $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("pin enable changed without a write");
  // Main scenarios
  read_cov: cover property (wb_ack_o && !wb_we_i);
  irq_cov: cover property ($rose(irq_o));
  pin_cov: cover property ($rose(rtc_pin_o));
endmodule // rtc_calendar_alarm_chk

bind rtc_calendar_alarm rtc_calendar_alarm_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .irq_o, .rtc_pin_o, .rtc_pin_oe_o);

/* verification/rtc_calendar_alarm_test.sv */
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_calendar_alarm_test;
  // ****
  // Stimulus and observed signals
  // ****
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc_tick = 1'b1; // Tick every cycle keeps a second at 32768 cycles
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack, irq, pin, pin_oe;
  logic [31:0] q;
  logic [15:0] cfg;
  logic [7:0] cal_val; // Calibration trim, drawn at random
  time t_evt; // When the previous alarm was seen
  logic [15:0] cfgs [3] = '{16'ha401, 16'hc000, 16'h8000}; // Yearly, chime wrap, self-clear
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  rtc_calendar_alarm dut (.clk_i(clk_i), .rst_i(rst_i), .osc_tick_i(osc_tick),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .rtc_pin_o(pin),
    .rtc_pin_oe_o(pin_oe));

  // ****
  // Helpers
  // ****
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the alarm waits and the seconds clock need about 82k cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 90000) begin
      bad_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled, take data there, then idle one cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Read and compare the lanes picked by m
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string what,
                    input logic [31:0] m = 32'hffffffff);
    bus(1'b0, a, 32'h0);
    chk(q & m, e, what);
  endtask

  // Expected configuration after one alarm event
  function automatic logic [15:0] after_event(input logic [15:0] c);
    if (c[7:0] != 8'h00) return {c[15:8], c[7:0] - 8'h01};
    if (c[14]) return {c[15:8], 8'hff};
    return {1'b0, c[14:0]};
  endfunction

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h0dbd));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`REG_ALCFG, 32'h0, "cfg reset");
    rd(`REG_CTRL, 32'h1, "ctrl reset");
    rd(`REG_DATE, 32'h00010106, "date reset");
    rd(5'h1c, 32'h0, "unmapped read");
    // Every interval code, disarmed, with random chime and repeat
    for (int i = 0; i < 10; i++) begin
      cfg = {1'b0, 1'($urandom), 4'(i), 2'b00, 8'($urandom)};
      wr(`REG_ALCFG, {16'h0, cfg});
      rd(`REG_ALCFG, {16'h0, cfg}, "cfg readback");
    end
    // Window walk from index 2 down, stopping at 0
    wr(`REG_ALCFG, 32'h0200);
    wr(`REG_ALVAL, 32'h0229);
    wr(`REG_ALVAL, 32'h0300);
    wr(`REG_ALVAL, 32'h0000);
    rd(`REG_ALCFG, 32'h0, "index stops at zero");
    wr(`REG_ALCFG, 32'h0200);
    rd(`REG_ALVAL, 32'h0229, "month day", 32'hffff);
    rd(`REG_ALVAL, 32'h0300, "weekday hour", 32'hffff);
    rd(`REG_ALVAL, 32'h0000, "minute second", 32'hffff);
    wr(`REG_ALCFG, 32'h0300);
    rd(`REG_ALVAL, 32'h0, "index three");
    rd(`REG_ALCFG, 32'h0200, "index after read");
    // Leap-year eve, one second before midnight, pin on alarm pulse
    wr(`REG_IRQ_MASK, 32'h1);
    cal_val = 8'($urandom_range(127, 1)); // Positive trim shortens the half after midnight
    wr(`REG_CTRL, {16'h0, cal_val, 8'h03});
    wr(`REG_DATE, 32'h12022803);
    wr(`REG_TIME, 32'h00235959);
    for (int i = 0; i < 3; i++) begin
      cfg = cfgs[i];
      wr(`REG_ALCFG, {16'h0, cfg});
      while (irq !== 1'b1) @(posedge clk_i);
      // The half after the midnight calibration is shorter by the trim
      if (i == 1) begin
        chk(32'(($time - t_evt) / 20), 32'd16384 - {24'h0, cal_val}, "half after cal");
      end
      t_evt = $time;
      repeat (2) @(posedge clk_i);
      chk({31'h0, pin}, 32'h1, "alarm pulse on pin");
      chk({31'h0, pin_oe}, 32'h1, "pin enabled");
      rd(`REG_ALCFG, {16'h0, after_event(cfg)}, "cfg after event");
      rd(`REG_IRQ_ST, 32'h1, "alarm status", 32'h1);
      if (i == 0) begin
        rd(`REG_TIME, 32'h0, "midnight", 32'h00ffffff);
        rd(`REG_DATE, 32'h12022904, "leap day");
        rd(`REG_IRQ_ST, 32'h3, "second status");
        wr(`REG_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(`REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1, "unmasked irq");
      end
      // Clear both status bits, then the level must fall
      wr(`REG_IRQ_ST, 32'h3);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0, "irq cleared");
    end
    // Seconds clock on the pin: high in the first half, low in the second
    wr(`REG_CTRL, 32'h7);
    wr(`REG_TIME, 32'h00120000);
    repeat (3) @(posedge clk_i);
    chk({31'h0, pin}, 32'h1, "seconds clock high");
    repeat (16384) @(posedge clk_i);
    chk({31'h0, pin}, 32'h0, "seconds clock low");
    rd(`REG_TIME, 32'h01120000, "half phase set");
    complete_run();
  end
endmodule // rtc_calendar_alarm_test
